// *** rtl/srf_core.sv ***
// Serial frame receiver, readback shifter and alarm line aggregation.
// Assumes the serial pins are asynchronous to sys_clk, and the serial
// clock is at most a quarter of sys_clk so that every edge is seen.
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps

// What this block does
// - Alarm line released when no fault, pulled low when any enabled fault is active.
// - Readback frames carry alarm state bit equal to inverted alarm pin level.
// - Cal CRC and four comparator errors always drive the alarm; clock count error does unless quiet.
// - Nine listed errors drive the alarm unless their mask bit is set.
// - Cal-unrefreshed and reset-detected flags never drive the alarm.
// - Quiet bit 3 of general config one keeps clock count error off alarm.
// - Access to a reserved register index raises the invalid-access flag.
// - With CRC on, frames are exactly 32 bits, last 8 being CRC.
// - With CRC off, accept 24-bit and 32-bit frames, ignoring last 8.
// - Frame: slip D23, address D22:D21, index D20:D16, payload D15:D0.
// - Slip bit must be inverse of D22, else slip error is flagged.
// - Act on a frame only when its address matches the strap pins.
// - Two-stage readback: select index, then no-op frame shifts data out.
// - New selection accepted during the returning frame; data follows next frame.
// - Readback top two bits are 0b10 at D31:D30 or D23:D22.
// - Autostatus style shifts status contents out during every frame.
// - Shared-select style outputs status only after a frame to it passes length, CRC and slip checks.
// - Echo style alternates status with echo of previous command word.
// - Status exposes digital and analog diagnostic summary bits.
// - Summaries are unlatched ORs, the digital one taking in the sticky link flags; slew-busy excluded from digital summary.
// - No-operation register payload always reads back as zeros.
module srf_core
  import srf_pkg::*;
#(
  parameter int FRAME_MAX = FRAME_LEN_CRC
)(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Serial link pins
  input  wire srf_link_t   link_in,
  output logic             sdo,
  // Address straps
  input  wire logic        addr_strap_hi,
  input  wire logic        addr_strap_lo,
  // Link CRC checker result and enable (CRC arithmetic lives outside)
  input  wire logic        link_crc_en,
  input  wire logic        link_crc_ok,
  // Diagnostic sources
  input  wire srf_diag_t   diag_in,
  // Register bank: write out, read data in
  output srf_wr_t          reg_wr,
  output logic [4:0]       rd_index,
  input  wire logic [15:0] rd_data,
  // Link error flags (one-cycle pulses)
  output logic             link_count_err,
  output logic             link_slip_err,
  output logic             link_crc_err,
  output logic             invalid_access,
  // Shared alarm line, open drain: enable low means pull low
  input  wire logic        alarm_in,
  output logic             alarm_out,
  output logic             alarm_oe_n
);

  typedef struct packed {
    logic [2:0]        sclk_s;
    logic [2:0]        frm_s;
    logic [2:0]        sdi_s;
    logic [2:0]        alm_s;
    logic              sclk_q;
    logic              frm_q;
    logic [FRAME_MAX-1:0] shift_in;
    logic [5:0]        bit_cnt;
    logic [31:0]       shift_out;
    logic [15:0]       gen_cfg_one;
    logic [15:0]       alarm_mask;
    logic [15:0]       rb_select;
    logic [23:0]       last_cmd;
    logic              echo_phase;
    logic              shared_flag;
    logic              drive_sdo;
    logic              alarm_oe_n;
    logic              alarm_out;
    logic              sdo;
    srf_wr_t           reg_wr;
    logic [4:0]        rd_index;
    logic              cnt_err;
    logic              slip_err;
    logic              crc_err;
    logic              acc_err;
    logic              cnt_sticky;
    logic              slip_sticky;
    logic              crc_sticky;
    logic              acc_sticky;
  } srf_state_t;

  srf_state_t st_reg;
  srf_state_t st_next;

  // Reserved indices: gaps in the map and anything past the last one
  function automatic logic is_reserved(input logic [4:0] idx);
    is_reserved = (idx >= 5'h0b && idx <= 5'h0f) || idx == 5'h11 ||
                  (idx >= 5'h19 && idx <= 5'h1b) || idx > IDX_LAST;
  endfunction : is_reserved

  logic        sclk_rise;
  logic        sclk_fall;
  logic        frm_fall;
  logic        frm_rise;
  logic        frm_low;
  logic        alarm_low;
  logic        dig_summary;
  logic        ana_summary;
  logic        fault_any;
  logic [23:0] word;
  logic        len_ok;
  logic        addr_ok;
  logic        slip_ok;
  logic [15:0] status_word;
  logic [23:0] rb_frame;
  logic [1:0]  mode;

  // Edge detection on the agreeing second and third stages only
  always_comb
  begin
    frm_low   = st_reg.frm_s[2] & st_reg.frm_s[1] ? 1'b0 :
                (~st_reg.frm_s[2] & ~st_reg.frm_s[1]) ? 1'b1 : ~st_reg.frm_q;
    sclk_rise = (st_reg.sclk_s[2] & st_reg.sclk_s[1]) & ~st_reg.sclk_q;
    sclk_fall = (~st_reg.sclk_s[2] & ~st_reg.sclk_s[1]) & st_reg.sclk_q;
    frm_fall  = frm_low & st_reg.frm_q;
    frm_rise  = ~frm_low & ~st_reg.frm_q;
    alarm_low = ~st_reg.alm_s[2] & ~st_reg.alm_s[1];
  end

  // Summaries are plain ORs, not latched themselves; the digital one includes the sticky link flags
  always_comb
  begin
    dig_summary = diag_in.osc_stop | diag_in.latch_mon | diag_in.inverse_chk |
                  diag_in.cal_crc | diag_in.cal_unrefreshed | diag_in.reset_seen |
                  st_reg.cnt_sticky | st_reg.slip_sticky | st_reg.crc_sticky | st_reg.acc_sticky;
    ana_summary = diag_in.open_circuit | diag_in.short_circuit | diag_in.die_temp |
                  diag_in.refout_cmp | diag_in.refin_cmp | diag_in.avcc_cmp | diag_in.ldo_cmp;
  end

  // Alarm sources; unrefreshed and reset-seen are left out on purpose
  always_comb
  begin
    fault_any = diag_in.cal_crc | diag_in.refout_cmp | diag_in.refin_cmp |
                diag_in.avcc_cmp | diag_in.ldo_cmp;
    fault_any = fault_any | (st_reg.cnt_sticky & ~st_reg.gen_cfg_one[POS_LINK_QUIET]);
    fault_any = fault_any |
      (diag_in.osc_stop      & ~st_reg.alarm_mask[MSK_OSC_STOP]) |
      (diag_in.latch_mon     & ~st_reg.alarm_mask[MSK_LATCH])    |
      (diag_in.inverse_chk   & ~st_reg.alarm_mask[MSK_INVERSE])  |
      (st_reg.acc_sticky     & ~st_reg.alarm_mask[MSK_ACCESS])   |
      (st_reg.slip_sticky    & ~st_reg.alarm_mask[MSK_SLIP])     |
      (st_reg.crc_sticky     & ~st_reg.alarm_mask[MSK_LINK_CRC]) |
      (diag_in.open_circuit  & ~st_reg.alarm_mask[MSK_OPEN])     |
      (diag_in.short_circuit & ~st_reg.alarm_mask[MSK_SHORT])    |
      (diag_in.die_temp      & ~st_reg.alarm_mask[MSK_TEMP]);
  end

  // Decode of the captured frame, MSB first
  always_comb
  begin
    word    = (st_reg.bit_cnt == 6'(FRAME_LEN_CRC)) ? st_reg.shift_in[31:8] : st_reg.shift_in[23:0];
    len_ok  = link_crc_en ? (st_reg.bit_cnt == 6'(FRAME_LEN_CRC))
                          : (st_reg.bit_cnt == 6'(FRAME_LEN_PLAIN) ||
                             st_reg.bit_cnt == 6'(FRAME_LEN_CRC));
    slip_ok = word[POS_SLIP] == ~word[POS_ADDR_HI];
    addr_ok = word[POS_ADDR_HI] == addr_strap_hi && word[POS_ADDR_LO] == addr_strap_lo;
    mode    = st_reg.rb_select[RB_MODE_LSB +: 2];
    status_word = {2'h0, alarm_low, dig_summary, ana_summary, 11'h000};
    rb_frame = {SYNC_MARK, alarm_low, st_reg.rb_select[RB_SEL_LSB +: 5],
                (st_reg.rb_select[RB_SEL_LSB +: 5] == IDX_NOP) ? 16'h0000 : rd_data};
  end

  always_comb
  begin
    st_next = st_reg;
    // Three-stage samplers for every link and alarm pin
    st_next.sclk_s = {st_reg.sclk_s[1:0], link_in.sclk};
    st_next.frm_s  = {st_reg.frm_s[1:0], link_in.frame_n};
    st_next.sdi_s  = {st_reg.sdi_s[1:0], link_in.sdi};
    st_next.alm_s  = {st_reg.alm_s[1:0], alarm_in};
    if (st_reg.sclk_s[2] == st_reg.sclk_s[1])
      st_next.sclk_q = st_reg.sclk_s[2];
    st_next.frm_q   = ~frm_low;
    st_next.reg_wr  = '0;
    st_next.cnt_err = 1'b0;
    st_next.slip_err = 1'b0;
    st_next.crc_err = 1'b0;
    st_next.acc_err = 1'b0;
    st_next.rd_index = st_reg.rb_select[RB_SEL_LSB +: 5];

    // Start of frame: load the outgoing word for the chosen style
    if (frm_fall)
    begin
      st_next.bit_cnt     = '0;
      st_next.shared_flag = 1'b0;
      st_next.drive_sdo   = 1'b1;
      case (mode)
        SRF_RB_TWO_STAGE: st_next.shift_out = {rb_frame, 8'h00};
        SRF_RB_AUTO:      st_next.shift_out = {SYNC_MARK, status_word[13:0], 8'h00, 8'h00};
        SRF_RB_SHARED:
        begin
          st_next.shift_out = {SYNC_MARK, status_word[13:0], 8'h00, 8'h00};
          st_next.drive_sdo = st_reg.shared_flag;
        end
        SRF_RB_ECHO:
        begin
          // Alternate frames return the previous command word
          st_next.shift_out  = st_reg.echo_phase ? {st_reg.last_cmd, 8'h00}
                                                 : {SYNC_MARK, status_word[13:0], 8'h00, 8'h00};
          st_next.echo_phase = ~st_reg.echo_phase;
        end
        default:          st_next.shift_out = '0;
      endcase
      // Short frames put the mark at D23 rather than D31
      if (!link_crc_en)
        st_next.shift_out = {st_next.shift_out[31:8], 8'h00};
    end

    // Capture on rising serial clock, shift out on falling
    if (frm_low && sclk_rise)
    begin
      st_next.shift_in = {st_reg.shift_in[FRAME_MAX-2:0], st_reg.sdi_s[2]};
      if (st_reg.bit_cnt != 6'h3f)
        st_next.bit_cnt = st_reg.bit_cnt + 6'h01;
    end
    if (frm_low && sclk_fall)
      st_next.shift_out = {st_reg.shift_out[30:0], 1'b0};
    st_next.sdo = st_reg.drive_sdo & st_reg.shift_out[31];

    // End of frame: length, CRC, slip and address checks
    if (frm_rise)
    begin
      st_next.drive_sdo = 1'b0;
      if (!len_ok)
        st_next.cnt_err = 1'b1;
      else if (link_crc_en && !link_crc_ok)
        st_next.crc_err = 1'b1;
      else if (!slip_ok)
        st_next.slip_err = 1'b1;
      else if (addr_ok)
      begin
        st_next.last_cmd = word;
        st_next.shared_flag = 1'b1;
        // A readback selection of a reserved index counts as a reserved read
        if (is_reserved(word[POS_IDX_MSB:POS_IDX_LSB]) ||
            (word[POS_IDX_MSB:POS_IDX_LSB] == IDX_RB_SELECT && is_reserved(word[RB_SEL_LSB +: 5])))
          st_next.acc_err = 1'b1;
        else
        begin
          st_next.reg_wr = '{valid: 1'b1, index: word[POS_IDX_MSB:POS_IDX_LSB], data: word[15:0]};
          case (word[POS_IDX_MSB:POS_IDX_LSB])
            IDX_GEN_CFG_ONE: st_next.gen_cfg_one = word[15:0];
            IDX_ALARM_MASK:  st_next.alarm_mask  = word[15:0];
            IDX_RB_SELECT:   st_next.rb_select   = word[15:0];
            default:         st_next.gen_cfg_one = st_reg.gen_cfg_one;
          endcase
        end
      end
    end

    // Sticky link flags; a fresh error wins over the write-1 clear
    if (st_reg.reg_wr.valid && st_reg.reg_wr.index == IDX_DIG_RESULTS)
    begin
      st_next.cnt_sticky  = st_reg.cnt_sticky  & ~st_reg.reg_wr.data[3];
      st_next.slip_sticky = st_reg.slip_sticky & ~st_reg.reg_wr.data[2];
      st_next.crc_sticky  = st_reg.crc_sticky  & ~st_reg.reg_wr.data[1];
      st_next.acc_sticky  = st_reg.acc_sticky  & ~st_reg.reg_wr.data[4];
    end
    st_next.cnt_sticky  = st_next.cnt_sticky  | st_next.cnt_err;
    st_next.slip_sticky = st_next.slip_sticky | st_next.slip_err;
    st_next.crc_sticky  = st_next.crc_sticky  | st_next.crc_err;
    st_next.acc_sticky  = st_next.acc_sticky  | st_next.acc_err;

    // Pull the shared line low only while a fault stands
    st_next.alarm_oe_n = ~fault_any;
    st_next.alarm_out  = 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_reg             <= '0;
      st_reg.sclk_s      <= 3'h0;
      st_reg.frm_s       <= 3'h7;
      st_reg.frm_q       <= 1'b1;
      st_reg.alm_s       <= 3'h7;
      st_reg.gen_cfg_one <= RST_GEN_CFG_ONE;
      st_reg.alarm_mask  <= RST_ALARM_MASK;
      st_reg.rb_select   <= RST_RB_SELECT;
      st_reg.alarm_oe_n  <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  // Outputs come straight from the state register
  assign sdo            = st_reg.sdo;
  assign reg_wr         = st_reg.reg_wr;
  assign rd_index       = st_reg.rd_index;
  assign link_count_err = st_reg.cnt_err;
  assign link_slip_err  = st_reg.slip_err;
  assign link_crc_err   = st_reg.crc_err;
  assign invalid_access = st_reg.acc_err;
  assign alarm_out      = st_reg.alarm_out;
  assign alarm_oe_n     = st_reg.alarm_oe_n;

endmodule : srf_core

// *** rtl/srf_pkg.sv ***
// Package for the serial register-access and alarm front end.
// Assumes one system clock; serial pins are sampled as ordinary inputs.
package srf_pkg;

  // Frame lengths and field positions (24-bit word, CRC byte below it)
  localparam int FRAME_LEN_CRC   = 32;
  localparam int FRAME_LEN_PLAIN = 24;
  localparam int CRC_LEN         = 8;
  localparam int POS_SLIP        = 23;
  localparam int POS_ADDR_HI     = 22;
  localparam int POS_ADDR_LO     = 21;
  localparam int POS_IDX_MSB     = 20;
  localparam int POS_IDX_LSB     = 16;
  localparam int POS_LINK_QUIET  = 3;

  // Register indices
  localparam logic [4:0] IDX_NOP          = 5'h00;
  localparam logic [4:0] IDX_GEN_CFG_ONE  = 5'h09;
  localparam logic [4:0] IDX_GEN_CFG_TWO  = 5'h0a;
  localparam logic [4:0] IDX_DIAG_CFG     = 5'h10;
  localparam logic [4:0] IDX_ALARM_MASK   = 5'h12;
  localparam logic [4:0] IDX_RB_SELECT    = 5'h13;
  localparam logic [4:0] IDX_DIG_RESULTS  = 5'h14;
  localparam logic [4:0] IDX_ANA_RESULTS  = 5'h15;
  localparam logic [4:0] IDX_STATUS       = 5'h16;
  localparam logic [4:0] IDX_LAST         = 5'h1c;

  // Reset values
  localparam logic [15:0] RST_GEN_CFG_ONE = 16'h0204;
  localparam logic [15:0] RST_ALARM_MASK  = 16'h0000;
  localparam logic [15:0] RST_RB_SELECT   = 16'h0000;
  localparam logic        RST_CRC_EN      = 1'b1;

  // Readback select register fields
  localparam int RB_SEL_LSB  = 0;
  localparam int RB_MODE_LSB = 8;
  localparam logic [1:0] SYNC_MARK = 2'h2;

  // Alarm mask bit positions (maskable sources)
  localparam int MSK_OSC_STOP = 0;
  localparam int MSK_LATCH    = 1;
  localparam int MSK_INVERSE  = 2;
  localparam int MSK_ACCESS   = 3;
  localparam int MSK_SLIP     = 4;
  localparam int MSK_LINK_CRC = 5;
  localparam int MSK_OPEN     = 6;
  localparam int MSK_SHORT    = 7;
  localparam int MSK_TEMP     = 8;

  typedef enum logic [1:0] {
    SRF_RB_TWO_STAGE = 2'h0,
    SRF_RB_AUTO      = 2'h1,
    SRF_RB_SHARED    = 2'h2,
    SRF_RB_ECHO      = 2'h3
  } srf_rb_mode_t;

  // Diagnostic inputs from the detectors outside this block
  typedef struct packed {
    logic osc_stop;
    logic latch_mon;
    logic inverse_chk;
    logic cal_crc;
    logic cal_unrefreshed;
    logic reset_seen;
    logic slew_busy;
    logic open_circuit;
    logic short_circuit;
    logic die_temp;
    logic refout_cmp;
    logic refin_cmp;
    logic avcc_cmp;
    logic ldo_cmp;
  } srf_diag_t;

  // Serial link pins
  typedef struct packed {
    logic sclk;
    logic frame_n;
    logic sdi;
  } srf_link_t;

  // Register write handed to the register bank outside
  typedef struct packed {
    logic        valid;
    logic [4:0]  index;
    logic [15:0] data;
  } srf_wr_t;

endpackage : srf_pkg

// *** test/srf_core_asserts.sv ***
// Checker for srf_core: timing and gating relations seen at the block's ports.
// Assumes binding into srf_core, one clock domain, synchronous active-high reset.
`timescale 1ns/1ps
module srf_core_asserts
  import srf_pkg::*;
#(
  parameter int FRAME_MAX = FRAME_LEN_CRC
)(
  // Clock and reset
  input wire logic      sys_clk,
  input wire logic      rst,
  // Watched ports
  input wire srf_link_t link_in,
  input wire logic      link_crc_en,
  input wire srf_diag_t diag_in,
  input wire srf_wr_t   reg_wr,
  input wire logic      link_count_err,
  input wire logic      link_slip_err,
  input wire logic      link_crc_err,
  input wire logic      invalid_access,
  input wire logic      alarm_out,
  input wire logic      alarm_oe_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Helper terms: any refusal pulse, and the diagnostic inputs no mask can hide
  logic any_err;
  logic hard;
  assign any_err = link_count_err | link_slip_err | link_crc_err | invalid_access;
  assign hard    = diag_in.cal_crc | diag_in.refout_cmp | diag_in.refin_cmp | diag_in.avcc_cmp | diag_in.ldo_cmp;

  a_pin_low_only: assert property (alarm_out == 1'b0)
    else $error("alarm line driven to a high level");
  a_hard_alarm: assert property (hard [*4] |-> !alarm_oe_n)
    else $error("unmaskable fault left alarm released");
  a_reset_quiet: assert property (disable iff (1'b0) rst |=> alarm_oe_n && !reg_wr.valid)
    else $error("alarm or write active after reset");
  a_wr_clean: assert property (reg_wr.valid |-> !any_err)
    else $error("refused frame still wrote");
  a_wr_frame_end: assert property (reg_wr.valid |-> link_in.frame_n && $past(link_in.frame_n, 2))
    else $error("write issued before frame select rose");
  a_err_frame_end: assert property (any_err |-> $past(link_in.frame_n, 2))
    else $error("frame error flagged inside a frame");
  a_idx_mapped: assert property (reg_wr.valid |-> reg_wr.index <= IDX_LAST &&
      !(reg_wr.index inside {[5'h0b:5'h0f], 5'h11, [5'h19:5'h1b]}))
    else $error("write reached a reserved index");
  a_crc_off: assert property (!link_crc_en [*8] |-> !link_crc_err)
    else $error("crc error with crc disabled");
endmodule : srf_core_asserts

// *** test/srf_host.sv ***
// Serial host model: frames words MSB first onto the link pins, collects sdo.
// Assumes sys_clk paces it; sclk idles low between frames, 8 sys_clk per bit.
// The pin synchronisers put about five sys_clk between an sclk fall and the new
// sdo bit, so sdo is taken just before each fall, not at the rise.
`timescale 1ns/1ps
module srf_host
  import srf_pkg::*;
(
  // Clock and returned data
  input wire logic sys_clk,
  input wire logic sdo,
  // Link pins
  output srf_link_t link
);
  initial link = '{sclk: 1'b0, frame_n: 1'b1, sdi: 1'b0};

  // Data line wanders between frames so a stale bit never reads as data
  always @(posedge sys_clk)
    if (link.frame_n)
      link.sdi <= ~link.sdi;

  // One frame of n bits; sdi set while sclk low, sdo taken before each fall
  task automatic send(input logic [31:0] w, input int n, output logic [31:0] rx);
    rx = '0;
    link.frame_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    for (int i = n - 1; i >= 0; i--)
    begin
      link.sdi <= w[i];
      repeat (4) @(posedge sys_clk);
      link.sclk <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rx[i] = sdo;
      link.sclk <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
    link.frame_n <= 1'b1;
    repeat (12) @(posedge sys_clk);
  endtask : send
endmodule : srf_host

// *** test/testbench.sv ***
// Testbench for srf_core: host frames commands; pulses, alarm and readback checked.
// Assumes straps give address 0b10 and an outside bank answers rd_index at once.
`timescale 1ns/1ps
module testbench;
  import srf_pkg::*;
  logic        sys_clk, rst, crc_en, crc_ok, sdo, alarm_out, alarm_oe_n;
  logic        e_cnt, e_slip, e_crc, e_acc;
  srf_link_t   link;
  srf_diag_t   diag;
  srf_wr_t     reg_wr;
  srf_wr_t     last_wr = '0;
  logic [4:0]  rd_index;
  logic [4:0]  rsv [3] = '{5'h0b, 5'h11, 5'h1b};
  logic [31:0] rx;
  int          errors = 0, checks_done = 0, ln = 32;
  int          n_wr, n_cnt, n_slip, n_crc, n_acc;

  // Outside bank: distinct per index so a wrong select shows
  function automatic logic [15:0] bank(input logic [4:0] i);
    return {i, i, i, 1'b1};
  endfunction : bank

  srf_host host (.sys_clk(sys_clk), .sdo(sdo), .link(link));
  // Alarm wire has a pull-up; only the low drive pulls it down
  srf_core dut (.sys_clk(sys_clk), .rst(rst), .link_in(link), .sdo(sdo), .addr_strap_hi(1'b1),
    .addr_strap_lo(1'b0), .link_crc_en(crc_en), .link_crc_ok(crc_ok), .diag_in(diag), .reg_wr(reg_wr),
    .rd_index(rd_index), .rd_data(bank(rd_index)), .link_count_err(e_cnt), .link_slip_err(e_slip),
    .link_crc_err(e_crc), .invalid_access(e_acc), .alarm_in(alarm_oe_n ? 1'b1 : alarm_out),
    .alarm_out(alarm_out), .alarm_oe_n(alarm_oe_n));

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Pulse counters, cleared by each frame
  always @(posedge sys_clk)
  begin
    n_wr += (reg_wr.valid === 1'b1);
    n_cnt += (e_cnt === 1'b1);
    n_slip += (e_slip === 1'b1);
    n_crc += (e_crc === 1'b1);
    n_acc += (e_acc === 1'b1);
    if (reg_wr.valid === 1'b1)
      last_wr = reg_wr;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic frame(input logic [23:0] w, input int n);
    {n_wr, n_cnt, n_slip, n_crc, n_acc} = 160'h0;
    ln = n;
    host.send(n == 24 ? {8'h00, w} : {w, 8'h00}, n, rx);
  endtask : frame

  // One edge first, so a crc_en change made just before is seen when the length is picked
  task automatic cmd(input logic [4:0] idx, input logic [15:0] d);
    @(posedge sys_clk);
    frame({1'b0, 2'b10, idx, d}, crc_en ? 32 : 24);
  endtask : cmd

  // Readback word sits in the first 24 bits shifted out
  function automatic logic [23:0] rb();
    return ln == 32 ? rx[31:8] : rx[23:0];
  endfunction : rb

  // Let the alarm path settle before looking at the enable
  task automatic alarm(input logic exp);
    repeat (4) @(posedge sys_clk);
    chk("alarm_oe_n", exp, alarm_oe_n);
  endtask : alarm

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results

  initial
  begin
    repeat (100000) @(posedge sys_clk);
    errors++;
    results();
  end

  initial
  begin
    rst = 1'b1;
    crc_en = 1'b1;
    crc_ok = 1'b1;
    diag = '0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    alarm(1'b1);
    cmd(IDX_ALARM_MASK, 16'h0000);
    chk("writes", 1, n_wr);
    chk("reg_wr", {1'b1, IDX_ALARM_MASK, 16'h0000}, last_wr);
    frame({1'b1, 2'b01, IDX_ALARM_MASK, 16'h0000}, 32);
    chk("foreign writes", 0, n_wr);
    // Bad slip bit, unmasked then masked
    for (int m = 0; m < 2; m++)
    begin
      cmd(IDX_ALARM_MASK, m ? 16'h0010 : 16'h0000);
      frame({1'b1, 2'b10, IDX_NOP, 16'h0000}, 32);
      chk("slip", 1, n_slip);
      chk("slip writes", 0, n_wr);
      alarm(m);
      cmd(IDX_DIG_RESULTS, 16'h0004);
      alarm(1'b1);
    end
    // Short frame in CRC mode: no mask hides it, only the quiet bit
    cmd(IDX_ALARM_MASK, 16'h01ff);
    for (int q = 0; q < 2; q++)
    begin
      cmd(IDX_GEN_CFG_ONE, RST_GEN_CFG_ONE | (q ? 16'h0008 : 16'h0000));
      frame({1'b0, 2'b10, IDX_NOP, 16'h0000}, 24);
      chk("count", 1, n_cnt);
      chk("count writes", 0, n_wr);
      alarm(q);
      cmd(IDX_DIG_RESULTS, 16'h0008);
    end
    cmd(IDX_GEN_CFG_ONE, RST_GEN_CFG_ONE);
    cmd(IDX_ALARM_MASK, 16'h0000);
    crc_ok <= 1'b0;
    cmd(IDX_ALARM_MASK, 16'h0000);
    chk("crc", 1, n_crc);
    chk("crc writes", 0, n_wr);
    alarm(1'b0);
    crc_ok <= 1'b1;
    cmd(IDX_DIG_RESULTS, 16'h0002);
    foreach (rsv[i])
    begin
      cmd(rsv[i], 16'h0000);
      chk("access", 1, n_acc);
      chk("access writes", 0, n_wr);
      alarm(1'b0);
      cmd(IDX_DIG_RESULTS, 16'h0010);
    end
    // Selecting a reserved index for readback is a reserved read
    cmd(IDX_RB_SELECT, 16'h0011);
    chk("select access", 1, n_acc);
    chk("select writes", 0, n_wr);
    cmd(IDX_DIG_RESULTS, 16'h0010);
    // Each detector alone, without and with every mask bit set
    for (int m = 0; m < 2; m++)
    begin
      cmd(IDX_ALARM_MASK, m ? 16'h01ff : 16'h0000);
      for (int i = 0; i < 14; i++)
      begin
        diag <= srf_diag_t'(14'h1 << i);
        alarm(i inside {7, 8, 9} || (m == 1 && i inside {4, 5, 6, 11, 12, 13}));
        diag <= '0;
        alarm(1'b1);
      end
    end
    // Two-stage readback, reselecting inside the returning frame
    cmd(IDX_ALARM_MASK, 16'h0000);
    cmd(IDX_RB_SELECT, 16'h0001);
    cmd(IDX_RB_SELECT, 16'h0003);
    chk("readback", {SYNC_MARK, 1'b0, 5'h01, bank(5'h01)}, rb());
    cmd(IDX_RB_SELECT, 16'h0000);
    chk("reselect", {SYNC_MARK, 1'b0, 5'h03, bank(5'h03)}, rb());
    cmd(IDX_NOP, 16'h0000);
    chk("nop readback", {SYNC_MARK, 1'b0, 5'h00, 16'h0000}, rb());
    // CRC off: short and long frames both land, checker result ignored
    crc_en <= 1'b0;
    crc_ok <= 1'b0;
    cmd(IDX_RB_SELECT, 16'h0005);
    chk("short writes", 1, n_wr);
    frame({1'b0, 2'b10, IDX_NOP, 16'h0000}, 32);
    chk("long writes", 1, n_wr);
    chk("long crc", 0, n_crc);
    chk("plain readback", {SYNC_MARK, 1'b0, 5'h05, bank(5'h05)}, rb());
    crc_en <= 1'b1;
    crc_ok <= 1'b1;
    cmd(IDX_RB_SELECT, 16'h0100);
    diag <= '{slew_busy: 1'b1, default: 1'b0};
    alarm(1'b1);
    cmd(IDX_NOP, 16'h0000);
    chk("status quiet", {SYNC_MARK, 3'b000, 19'h0}, rb());
    diag <= '{latch_mon: 1'b1, open_circuit: 1'b1, default: 1'b0};
    alarm(1'b0);
    cmd(IDX_NOP, 16'h0000);
    chk("status fault", {SYNC_MARK, 3'b111, 19'h0}, rb());
    diag <= '0;
    alarm(1'b1);
    cmd(IDX_RB_SELECT, 16'h0300);
    cmd(IDX_ALARM_MASK, 16'h0000);
    chk("echo status", {SYNC_MARK, 3'b000, 19'h0}, rb());
    cmd(IDX_NOP, 16'h0000);
    chk("echo word", {1'b0, 2'b10, IDX_ALARM_MASK, 16'h0000}, rb());
    // Shared select: status only after a frame to this device passes length, CRC and slip checks
    cmd(IDX_RB_SELECT, 16'h0200);
    frame({1'b1, 2'b01, IDX_NOP, 16'h0000}, 32);
    chk("shared after write", {SYNC_MARK, 3'b000, 19'h0}, rb());
    cmd(IDX_NOP, 16'h0000);
    chk("shared after foreign", 0, rb());
    results();
  end
endmodule : testbench

bind srf_core srf_core_asserts #(.FRAME_MAX(FRAME_MAX)) chk_i (.sys_clk(sys_clk), .rst(rst), .link_in(link_in),
  .link_crc_en(link_crc_en), .diag_in(diag_in), .reg_wr(reg_wr), .link_count_err(link_count_err),
  .link_slip_err(link_slip_err), .link_crc_err(link_crc_err), .invalid_access(invalid_access),
  .alarm_out(alarm_out), .alarm_oe_n(alarm_oe_n));
